// ===== logic/standard_timer.sv
// Standard 16-bit timer: counter, compare A and P, output pin logic
// Assumes a classic Wishbone master on clk_i and pins from outside
//
// Overview of operation
// - 16-bit up counter advanced by the selected count clock only.
// - Compare P checks counter top byte; compare A checks all 16 bits.
// - Compare A low byte writes go to buffer; its high byte write copies buffer low.
// - High byte read returns high, captures low byte into the buffer.
// - Rising counter_on clears the counter; software cannot load it.
// - Clearing counter_on stops counting and keeps the count.
// - Counter also clears on overflow or selected comparator match.
// - count_pause holds the counter; clearing it resumes counting.
// - clock_select picks sys/4, sys, high/16, high/64, sub, pin edge.
// - Rising counter_on sets the pin to its initial level.
// - op_mode_sel: compare output, undefined, PWM/pulse, timer.
// - Timer/counter mode leaves the output pin undriven.
// - Compare A match: no change, low, high or toggle the pin.
// - PWM mode: inactive, active, PWM waveform or single pulse.
// - Drive level equal to the current level leaves the pin unchanged.
// - Control 0 bits 2 to 0 always read as zero.
// - Counter readable as read-only pair; compare A a read/write pair.
// - output_initial_level: initial level, or active level in PWM.
// - output_invert inverts the pin in compare output and PWM modes only.
// - clear_source_sel picks A or P match outside PWM mode; P of zero means overflow.
// - duty_period_swap swaps period and duty compares for PWM.
//
// Chosen here: register access over Wishbone and the placing of the registers.

`timescale 1ns/10ps

module standard_timer
	import standard_timer_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Clock source pins
	input  wire logic        ext_clock_pin_i,
	input  wire logic        high_clk_i,
	input  wire logic        sub_clk_i,
	// Output pin and match pulses
	output logic             timer_output_pin_o,
	output logic             timer_output_oe_o,
	output logic             match_a_o,
	output logic             match_p_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ctrl0_t                   ctrl0;
	ctrl1_t                   ctrl1;
	logic [`CNT_W-1:0]        cnt;
	logic [`CNT_W-1:0]        cmp_a;
	logic [`BYTE_W-1:0]       cmp_p;
	logic [`BYTE_W-1:0]       hold_buf;
	logic                     on_d;
	logic                     out_level;
	logic                     pulse_done;
	logic [2:0]               sync1;
	logic [2:0]               sync2;
	logic [2:0]               sync3;
	logic [`SYS_DIV_W-1:0]    sys_div;
	logic [`HIGH_DIV_W-1:0]   high_div;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire req       = cyc_i & stb_i;
	wire acc       = req & ack_o & ce_i;
	wire wr_acc    = acc & we_i & sel_i[0];
	// Reads latch data and capture the low byte buffer on one edge
	wire rd_acc    = req & ~ack_o & ~we_i & ce_i;
	wire [7:0] wd  = dat_i[7:0];
	wire sel_c0    = adr_i == `OFS_CTRL0;
	wire sel_c1    = adr_i == `OFS_CTRL1;
	wire sel_dl    = adr_i == `OFS_CNT_LO;
	wire sel_dh    = adr_i == `OFS_CNT_HI;
	wire sel_al    = adr_i == `OFS_CMPA_LO;
	wire sel_ah    = adr_i == `OFS_CMPA_HI;
	wire sel_p     = adr_i == `OFS_CMPP;
	wire [7:0] c0_rd = ctrl0 & `CTRL0_RD_MASK;
	wire [7:0] rd_byte =
		sel_c0 ? c0_rd :
		sel_c1 ? ctrl1 :
		sel_dh ? cnt[15:8] :
		sel_ah ? cmp_a[15:8] :
		sel_p  ? cmp_p :
		(sel_dl | sel_al) ? hold_buf :
		8'h00;

	// ----------------------------------------------------------------
	// Wishbone answer: ack one cycle after the request, then drop
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else if (ce_i) begin
			ack_o <= req & ~ack_o;
			if (req & ~ack_o)
				dat_o <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// Registers and shared low byte buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0    <= `CTRL0_RST;
			ctrl1    <= `CTRL1_RST;
			cmp_a    <= 16'h0000;
			cmp_p    <= `CMPP_RST;
			hold_buf <= 8'h00;
		end else begin
			if (wr_acc & sel_c0)
				ctrl0 <= wd & `CTRL0_RD_MASK;
			if (wr_acc & sel_c1)
				ctrl1 <= wd;
			if (wr_acc & sel_p)
				cmp_p <= wd;
			if (wr_acc & sel_al)
				hold_buf <= wd;
			if (wr_acc & sel_ah)
				cmp_a <= {wd, hold_buf};
			if (rd_acc & sel_dh)
				hold_buf <= cnt[7:0];
			if (rd_acc & sel_ah)
				hold_buf <= cmp_a[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers: ext clock, high clock, sub clock
	// ----------------------------------------------------------------
	wire [2:0] pins = {sub_clk_i, high_clk_i, ext_clock_pin_i};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
				end else if (ce_i) begin
					sync1[gi] <= pins[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
				end
			end
		end
	endgenerate

	wire ext_rise  = sync2[0] & ~sync3[0];
	wire ext_fall  = ~sync2[0] & sync3[0];
	wire high_rise = sync2[1] & ~sync3[1];
	wire sub_rise  = sync2[2] & ~sync3[2];

	// ----------------------------------------------------------------
	// Count clock dividers and source selection
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_div  <= '0;
			high_div <= '0;
		end else if (ce_i) begin
			sys_div <= sys_div + 1'b1;
			if (high_rise)
				high_div <= high_div + 1'b1;
		end
	end

	wire sys4_tick = &sys_div;
	wire h16_tick  = high_rise &
		((high_div & `HIGH_DIV16_MSK) == `HIGH_DIV16_MSK);
	wire h64_tick  = high_rise & (high_div == `HIGH_DIV64_MSK);
	wire [7:0] src = {ext_fall, ext_rise, sub_rise, sub_rise,
		h64_tick, h16_tick, 1'b1, sys4_tick};
	wire tick      = src[ctrl0.clock_select];

	// ----------------------------------------------------------------
	// Compare and clear
	// ----------------------------------------------------------------
	wire on_rise   = ctrl0.counter_on & ~on_d;
	wire run       = ctrl0.counter_on & ~ctrl0.count_pause & tick;
	wire [15:0] nx = cnt + 16'h0001;
	wire hit_a     = run & (nx == cmp_a) & (cmp_a != 16'h0000);
	wire hit_p     = run & (nx[15:8] == cmp_p) & (nx[7:0] == 8'h00);
	wire is_pwm    = ctrl1.op_mode_sel == MODE_PWM;
	wire per_hit   = ctrl1.duty_period_swap ? hit_a : hit_p;
	wire sel_hit   = ctrl1.clear_source_sel ? hit_a : hit_p;
	wire clr_hit   = is_pwm ? per_hit : sel_hit;
	wire duty_on   = ctrl1.duty_period_swap ?
		(cnt[15:8] < cmp_p) : (cnt < cmp_a);
	wire ovf       = run & (nx == 16'h0000);
	wire next_clear = clr_hit | ovf;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt  <= 16'h0000;
			on_d <= 1'b0;
		end else if (ce_i) begin
			on_d <= ctrl0.counter_on;
			if (on_rise)
				cnt <= 16'h0000;
			else if (run)
				cnt <= next_clear ? 16'h0000 : nx;
		end
	end

	// ----------------------------------------------------------------
	// Match pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_a_o <= 1'b0;
			match_p_o <= 1'b0;
		end else if (ce_i) begin
			match_a_o <= hit_a & ~on_rise;
			match_p_o <= hit_p & ~on_rise &
				(is_pwm | ~ctrl1.clear_source_sel);
		end
	end

	// ----------------------------------------------------------------
	// Output pin level
	// ----------------------------------------------------------------
	wire oc = ctrl1.output_initial_level;
	wire [1:0] act = ctrl1.pin_action_sel;
	logic next_level;
	assign next_level =
		(act == 2'b01) ? 1'b0 :
		(act == 2'b10) ? 1'b1 :
		(act == 2'b11) ? ~out_level : out_level;
	wire pulse_act = ~pulse_done & ctrl0.counter_on;
	wire pwm_act =
		(act == 2'b00) ? 1'b0 :
		(act == 2'b01) ? 1'b1 :
		(act == 2'b10) ? (ctrl0.counter_on & duty_on) :
		pulse_act;
	wire cmp_mode = ctrl1.op_mode_sel == MODE_CMP;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_level  <= 1'b0;
			pulse_done <= 1'b0;
		end else if (ce_i) begin
			if (on_rise) begin
				out_level  <= oc;
				pulse_done <= 1'b0;
			end else if (cmp_mode & hit_a) begin
				out_level <= next_level;
			end else if (is_pwm) begin
				out_level <= pwm_act ? oc : ~oc;
				if (ctrl0.counter_on & (per_hit | hit_a | hit_p))
					pulse_done <= 1'b1;
			end
		end
	end

	assign timer_output_oe_o  = cmp_mode | is_pwm;
	assign timer_output_pin_o = timer_output_oe_o &
		(out_level ^ ctrl1.output_invert);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_on_clears_cnt: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & on_rise |=> cnt == 16'h0000)
		else $error("counter not cleared on counter_on rise");
	a_off_holds_cnt: assert property (
		@(posedge clk_i) disable iff (rst_i)
		~ctrl0.counter_on |=> cnt == $past(cnt))
		else $error("counter moved while off");
	a_pause_holds: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ctrl0.count_pause & ~on_rise |=> $stable(cnt))
		else $error("counter moved while paused");
	a_count_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & run & ~next_clear & ~on_rise
		|=> cnt == $past(cnt) + 16'h0001)
		else $error("counter did not advance by one");
	a_match_clears: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & run & sel_hit & ~is_pwm & ~on_rise
		|=> cnt == 16'h0000 && (match_a_o | match_p_o))
		else $error("counter not cleared on match");
	a_p_no_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & run & ~is_pwm & ctrl1.clear_source_sel & ~hit_a & ~ovf
		& ~on_rise |=> cnt == $past(cnt) + 16'h0001)
		else $error("counter cleared without a compare A match");
	a_hi_write_copy: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_acc & sel_ah
		|=> cmp_a == {$past(dat_i[7:0]), $past(hold_buf)})
		else $error("compare A pair not updated from buffer");
	a_hi_read_capt: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd_acc & sel_dh |=> hold_buf == $past(cnt[7:0])
		&& dat_o[7:0] == $past(cnt[15:8]))
		else $error("counter bytes not taken on one edge");
	a_c0_low_zero: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ack_o & ~we_i & sel_c0 |-> dat_o[2:0] == 3'b000)
		else $error("control 0 low bits not zero");
	a_pin_initial: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & on_rise & (cmp_mode | is_pwm)
		|=> out_level == $past(oc))
		else $error("pin not set to initial level");
	a_cmp_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cmp_mode & ~on_rise & ~hit_a |=> $stable(out_level))
		else $error("compare output changed without a match");
	a_pwm_inactive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & is_pwm & ~on_rise & (act == 2'b00)
		|=> out_level == ~$past(oc))
		else $error("forced inactive level not driven");
	a_match_pulse: assert property (
		@(posedge clk_i) disable iff (rst_i)
		match_a_o & ce_i |=> ~match_a_o | $past(hit_a))
		else $error("match A pulse without a match");
	a_p_suppressed: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i & ~is_pwm & ctrl1.clear_source_sel |=> ~match_p_o)
		else $error("compare P pulse while compare A clears");

endmodule // standard_timer

// ===== logic/standard_timer_consts.svh
// Register offsets, widths, reset values, masks and divider counts
// Assumes inclusion by the timer package and the testbench
`ifndef STANDARD_TIMER_CONSTS_SVH
`define STANDARD_TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_CNT_LO     8'h08
`define OFS_CNT_HI     8'h0C
`define OFS_CMPA_LO    8'h10
`define OFS_CMPA_HI    8'h14
`define OFS_CMPP       8'h18

// ----------------------------------------------------------------
// Widths, reset values, masks
// ----------------------------------------------------------------
`define CNT_W          16
`define BYTE_W         8
`define CTRL0_RST      8'h00
`define CTRL1_RST      8'h00
`define CMPP_RST       8'h00
`define CTRL0_RD_MASK  8'hF8

// ----------------------------------------------------------------
// Count clock dividers
// ----------------------------------------------------------------
`define SYS_DIV_W      2
`define HIGH_DIV_W     6
`define HIGH_DIV16_MSK 6'h0F
`define HIGH_DIV64_MSK 6'h3F

`endif

// ===== logic/standard_timer_pkg.sv
// Types shared by the standard timer design
// Assumes the constants header sits beside it
package standard_timer_pkg;
	`include "standard_timer_consts.svh"

	typedef enum logic [1:0] {
		MODE_CMP   = 2'b00,
		MODE_UNDEF = 2'b01,
		MODE_PWM   = 2'b10,
		MODE_TIMER = 2'b11
	} op_mode_t;

	typedef struct packed {
		logic       count_pause;
		logic [2:0] clock_select;
		logic       counter_on;
		logic [2:0] unused;
	} ctrl0_t;

	typedef struct packed {
		op_mode_t   op_mode_sel;
		logic [1:0] pin_action_sel;
		logic       output_initial_level;
		logic       output_invert;
		logic       duty_period_swap;
		logic       clear_source_sel;
	} ctrl1_t;
endpackage

// ===== tb/testbench.sv
// Self-checking bench for the standard timer
// Assumes the timer package and module are compiled before this file
`timescale 1ns/10ps
`include "standard_timer_consts.svh"

module testbench;
	import standard_timer_pkg::*;

	typedef struct packed {
		logic [7:0] adr;
		logic       we;
		logic [7:0] wd;
		logic [7:0] exp;
	} row_t;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic        ext_i = 1'b0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        pin_o;
	logic        oe_o;
	logic        ma_o;
	logic        mp_o;
	logic [31:0] rd;
	logic [15:0] c1;
	logic [15:0] c2;
	logic        e;
	int          err_total = 0;
	int          n_tests = 0;
	int          i;
	int          n;
	row_t        rows [19];

	standard_timer DUT (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_clock_pin_i(ext_i), .high_clk_i(ext_i), .sub_clk_i(ext_i),
		.timer_output_pin_o(pin_o), .timer_output_oe_o(oe_o),
		.match_a_o(ma_o), .match_p_o(mp_o)
	);

	always #25 clk_i = ~clk_i;

	// ------------------------------------------------------------
	// Checks and bus cycles
	// ------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Holds the request until ack is sampled high, then releases
	task automatic wb(input logic [7:0] a, input logic w,
			input logic [7:0] d);
		int k;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (k >= 50) begin
			err_total++;
			test_done();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// High byte first, so the low byte comes from the same count
	task automatic rdcnt(output logic [15:0] c);
		wb(`OFS_CNT_HI, 1'b0, 8'h00);
		c[15:8] = rd[7:0];
		wb(`OFS_CNT_LO, 1'b0, 8'h00);
		c[7:0] = rd[7:0];
	endtask

	task automatic wait_m(input bit p, input int lim, output int c);
		c = 0;
		do begin
			@(posedge clk_i);
			c++;
		end while ((p ? mp_o : ma_o) !== 1'b1 && c < lim);
		if (c >= lim) begin
			err_total++;
			test_done();
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rows = '{
			'{`OFS_CTRL0, 1'b0, 8'h00, 8'h00},
			'{`OFS_CTRL1, 1'b0, 8'h00, 8'h00},
			'{`OFS_CNT_LO, 1'b0, 8'h00, 8'h00},
			'{`OFS_CNT_HI, 1'b0, 8'h00, 8'h00},
			'{`OFS_CMPA_HI, 1'b0, 8'h00, 8'h00},
			'{`OFS_CMPA_LO, 1'b0, 8'h00, 8'h00},
			'{`OFS_CMPP, 1'b0, 8'h00, 8'h00},
			'{`OFS_CTRL0, 1'b1, 8'hFF, 8'h00},
			'{`OFS_CTRL0, 1'b0, 8'h00, 8'hF8},
			'{`OFS_CTRL1, 1'b1, 8'h3A, 8'h00},
			'{`OFS_CTRL1, 1'b0, 8'h00, 8'h3A},
			'{`OFS_CMPP, 1'b1, 8'h5A, 8'h00},
			'{`OFS_CMPP, 1'b0, 8'h00, 8'h5A},
			'{`OFS_CNT_HI, 1'b1, 8'hFF, 8'h00},
			'{`OFS_CNT_HI, 1'b0, 8'h00, 8'h00},
			'{8'h20, 1'b1, 8'h77, 8'h00},
			'{8'h20, 1'b0, 8'h00, 8'h00},
			'{`OFS_CTRL0, 1'b1, 8'h00, 8'h00},
			'{`OFS_CTRL1, 1'b1, 8'h00, 8'h00}};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (i = 0; i < 19; i++) begin
			wb(rows[i].adr, rows[i].we, rows[i].wd);
			if (!rows[i].we) chk(rd, {24'h0, rows[i].exp});
		end
		$display("register table done");
		wb(`OFS_CMPA_LO, 1'b1, 8'h34);
		wb(`OFS_CMPA_HI, 1'b0, 8'h00);
		wb(`OFS_CMPA_LO, 1'b0, 8'h00);
		chk(rd, 32'h0);
		wb(`OFS_CMPA_LO, 1'b1, 8'h34);
		wb(`OFS_CMPA_HI, 1'b1, 8'h12);
		wb(`OFS_CMPA_HI, 1'b0, 8'h00);
		chk(rd, 32'h12);
		wb(`OFS_CMPA_LO, 1'b0, 8'h00);
		chk(rd, 32'h34);
		$display("byte buffer done");
		wb(`OFS_CMPP, 1'b1, 8'h01);
		for (i = 0; i < 2; i++) begin
			wb(`OFS_CTRL0, 1'b1, i ? 8'h08 : 8'h18);
			wait_m(1'b1, 2000, n);
			wait_m(1'b1, 2000, n);
			chk(n, i ? 1024 : 256);
			@(posedge clk_i);
			chk_bit(mp_o, 1'b0);
			wb(`OFS_CTRL0, 1'b1, 8'h00);
		end
		$display("compare P period done");
		wb(`OFS_CMPP, 1'b1, 8'h00);
		wb(`OFS_CTRL0, 1'b1, 8'h18);
		repeat (40) @(posedge clk_i);
		wb(`OFS_CTRL0, 1'b1, 8'h98);
		rdcnt(c1);
		repeat (20) @(posedge clk_i);
		rdcnt(c2);
		chk(c2, c1);
		chk_bit(c1 >= 16'd40, 1'b1);
		wb(`OFS_CTRL0, 1'b1, 8'h18);
		rdcnt(c2);
		chk_bit(c2 > c1 && c2 < c1 + 16'd20, 1'b1);
		wb(`OFS_CTRL0, 1'b1, 8'h10);
		rdcnt(c1);
		repeat (20) @(posedge clk_i);
		rdcnt(c2);
		chk(c2, c1);
		wb(`OFS_CTRL0, 1'b1, 8'h18);
		rdcnt(c2);
		chk_bit(c2 < 16'd10, 1'b1);
		$display("pause and on/off done");
		wb(`OFS_CMPA_LO, 1'b1, 8'h05);
		wb(`OFS_CMPA_HI, 1'b1, 8'h00);
		for (i = 0; i < 16; i++) begin
			wb(`OFS_CTRL0, 1'b1, 8'h10);
			wb(`OFS_CTRL1, 1'b1, {4'h0, i[3:2], 2'b01} | {i[1:0], 4'h0});
			wb(`OFS_CTRL0, 1'b1, 8'h18);
			@(posedge clk_i);
			chk_bit(pin_o, i[3] ^ i[2]);
			chk_bit(oe_o, 1'b1);
			wait_m(1'b0, 50, n);
			@(posedge clk_i);
			e = (i[1:0] == 2'd0) ? i[3] : (i[1:0] == 2'd3) ? ~i[3] : i[1];
			chk_bit(pin_o, e ^ i[2]);
		end
		$display("pin actions done");
		for (i = 0; i < 4; i++) begin
			wb(`OFS_CTRL0, 1'b1, 8'h00);
			wb(`OFS_CTRL1, 1'b1, {i[1:0], 6'h00});
			chk_bit(oe_o, ~i[0]);
		end
		// Period P of 256 ticks, duty A of 5 ticks, active high
		wb(`OFS_CMPP, 1'b1, 8'h01);
		for (i = 0; i < 4; i++) begin
			wb(`OFS_CTRL0, 1'b1, 8'h00);
			wb(`OFS_CTRL1, 1'b1, {2'b10, i[1:0], 4'h8});
			wb(`OFS_CTRL0, 1'b1, 8'h18);
			wait_m(1'b1, 600, n);
			@(posedge clk_i);
			chk_bit(pin_o, i[0] ^ i[1]);
			repeat (10) @(posedge clk_i);
			chk_bit(pin_o, i == 1);
		end
		$display("PWM outputs done");
		// One pin feeds all sources; high clock is divided by 16
		for (i = 0; i < 4; i++) begin
			wb(`OFS_CTRL0, 1'b1, 8'h00);
			wb(`OFS_CTRL0, 1'b1, (i == 0) ? 8'h68 : (i == 1) ? 8'h78 :
				(i == 2) ? 8'h48 : 8'h28);
			repeat (16) begin
				repeat (4) @(posedge clk_i);
				ext_i <= 1'b1;
				repeat (4) @(posedge clk_i);
				ext_i <= 1'b0;
			end
			repeat (6) @(posedge clk_i);
			rdcnt(c1);
			chk(c1, (i == 3) ? 16'd1 : 16'd16);
		end
		$display("modes and pin edges done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(`OFS_CTRL1, 1'b0, 8'h00);
		chk(rd, 32'h0);
		chk_bit(oe_o, 1'b1);
		$display("second reset done");
		test_done();
	end
endmodule // testbench
